/* adc_result_compare_status.sv */
// Purpose: Result comparators and the converter status register of an A/D converter.
// Assumes: All converter and result-queue inputs come from logic on clk_sys_i.
// Notes: Pending/mask registers gate the status events onto irq_o.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "adc_cmp_consts.svh"

module adc_result_compare_status (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [`ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [`DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [`ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [`DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic result_load_i,
	input wire logic [`CHANNEL_W-1:0] result_channel_i,
	input wire logic [`RESULT_W-1:0] result_value_i,
	input wire logic conv_start_i,
	input wire logic conv_end_i,
	input wire logic pwm_single_seq_i,
	input wire logic queue_half_i,
	input wire logic queue_overflow_i,
	input wire logic queue_empty_i,
	input wire logic queue_full_i,
	output logic compare_irq_o,
	output logic irq_o
);

	reg_access_if bus ();
	compare_unit_if cmp0 ();
	compare_unit_if cmp1 ();

	adc_cmp_pkg::word_t compare_config_0_reg;
	adc_cmp_pkg::word_t compare_config_1_reg;
	adc_cmp_pkg::word_t status_reg;
	adc_cmp_pkg::word_t status_next;
	adc_cmp_pkg::word_t pending_reg;
	adc_cmp_pkg::word_t pending_next;
	adc_cmp_pkg::word_t mask_reg;
	adc_cmp_pkg::word_t status_set;
	adc_cmp_pkg::word_t status_clr;
	adc_cmp_pkg::word_t pending_clr;
	logic queue_half_d_reg;
	logic queue_overflow_d_reg;
	logic queue_empty_d_reg;
	logic queue_full_d_reg;
	logic wr_cfg0;
	logic wr_cfg1;
	logic wr_status;
	logic wr_mask;
	logic rd_pending;
	logic single_done_set;
	logic single_done_hw_clr;
	logic compare_irq_enable_0;
	logic compare_irq_enable_1;

	axil_reg_slave u_slave (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.bus(bus.slave)
	);

	// Comparator configuration fields.
	assign cmp0.compare_reference = compare_config_0_reg[`CFG_REF_HI:`CFG_REF_LO];
	assign cmp0.match_count_threshold = compare_config_0_reg[`CFG_THR_HI:`CFG_THR_LO];
	assign cmp0.compare_channel_select = compare_config_0_reg[`CFG_CH_HI:`CFG_CH_LO];
	assign cmp0.compare_condition = compare_config_0_reg[`CFG_COND];
	assign cmp0.compare_function_enable = compare_config_0_reg[`CFG_EN];
	assign cmp0.result_load = result_load_i;
	assign cmp0.result_channel = result_channel_i;
	assign cmp0.result_value = result_value_i;
	assign cmp1.compare_reference = compare_config_1_reg[`CFG_REF_HI:`CFG_REF_LO];
	assign cmp1.match_count_threshold = compare_config_1_reg[`CFG_THR_HI:`CFG_THR_LO];
	assign cmp1.compare_channel_select = compare_config_1_reg[`CFG_CH_HI:`CFG_CH_LO];
	assign cmp1.compare_condition = compare_config_1_reg[`CFG_COND];
	assign cmp1.compare_function_enable = compare_config_1_reg[`CFG_EN];
	assign cmp1.result_load = result_load_i;
	assign cmp1.result_channel = result_channel_i;
	assign cmp1.result_value = result_value_i;
	assign compare_irq_enable_0 = compare_config_0_reg[`CFG_IE];
	assign compare_irq_enable_1 = compare_config_1_reg[`CFG_IE];

	// A channel select above 7 matches any result whose result_channel_i holds the same 4-bit value; there is no range check.
	result_comparator u_cmp0 (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.cmp(cmp0.unit)
	);

	result_comparator u_cmp1 (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.cmp(cmp1.unit)
	);

	// Address decode.
	assign wr_cfg0 = bus.wr_en && (bus.wr_addr == `OFS_COMPARE_CONFIG_0);
	assign wr_cfg1 = bus.wr_en && (bus.wr_addr == `OFS_COMPARE_CONFIG_1);
	assign wr_status = bus.wr_en && (bus.wr_addr == `OFS_CONVERTER_STATUS);
	assign wr_mask = bus.wr_en && (bus.wr_addr == `OFS_IRQ_MASK);
	assign rd_pending = bus.rd_en && (bus.rd_addr == `OFS_IRQ_PENDING);
	assign bus.wr_hit = (bus.wr_addr == `OFS_COMPARE_CONFIG_0)
		|| (bus.wr_addr == `OFS_COMPARE_CONFIG_1) || (bus.wr_addr == `OFS_CONVERTER_STATUS)
		|| (bus.wr_addr == `OFS_IRQ_PENDING) || (bus.wr_addr == `OFS_IRQ_MASK);
	assign bus.rd_hit = (bus.rd_addr == `OFS_COMPARE_CONFIG_0)
		|| (bus.rd_addr == `OFS_COMPARE_CONFIG_1) || (bus.rd_addr == `OFS_CONVERTER_STATUS)
		|| (bus.rd_addr == `OFS_IRQ_PENDING) || (bus.rd_addr == `OFS_IRQ_MASK);
	assign bus.rd_data = (bus.rd_addr == `OFS_COMPARE_CONFIG_0) ? compare_config_0_reg :
		(bus.rd_addr == `OFS_COMPARE_CONFIG_1) ? compare_config_1_reg :
		(bus.rd_addr == `OFS_CONVERTER_STATUS) ? status_reg :
		(bus.rd_addr == `OFS_IRQ_PENDING) ? pending_reg :
		(bus.rd_addr == `OFS_IRQ_MASK) ? mask_reg : `RESET_WORD;

	// Hardware set terms of the status word.
	assign single_done_set = conv_end_i && pwm_single_seq_i;
	assign single_done_hw_clr = status_reg[`ST_SINGLE_CLEAR_MODE] && conv_start_i;

	always_comb begin
		status_set = `RESET_WORD;
		status_set[`ST_QUEUE_HALF] = queue_half_i;
		status_set[`ST_QUEUE_OVERFLOW] = queue_overflow_i;
		status_set[`ST_QUEUE_EMPTY] = queue_empty_i;
		status_set[`ST_QUEUE_FULL] = queue_full_i;
		status_set[`ST_COMPARE_FLAG_1] = cmp1.hit;
		status_set[`ST_COMPARE_FLAG_0] = cmp0.hit;
		status_set[`ST_CONV_END] = conv_end_i;
		status_set[`ST_QUEUE_HALF_IRQ] = queue_half_i && !queue_half_d_reg;
		status_set[`ST_QUEUE_OVERFLOW_IRQ] = queue_overflow_i && !queue_overflow_d_reg;
		status_set[`ST_QUEUE_EMPTY_IRQ] = queue_empty_i && !queue_empty_d_reg;
		status_set[`ST_QUEUE_FULL_IRQ] = queue_full_i && !queue_full_d_reg;
		status_set[`ST_SINGLE_DONE] = single_done_set;
		status_set[`ST_COMPARE_IRQ_FLAG_1] = cmp1.hit;
		status_set[`ST_COMPARE_IRQ_FLAG_0] = cmp0.hit;
	end

	always_comb begin
		status_clr = `RESET_WORD;
		if (wr_status) begin
			status_clr = bus.wr_data & bus.wr_lanes & `ST_W1C_MASK;
		end
		// In hardware mode software writes still clear; both paths are harmless together.
		status_clr[`ST_SINGLE_DONE] = status_clr[`ST_SINGLE_DONE] || single_done_hw_clr;
		// A set in the same cycle as a clear wins, so no event is lost.
		status_next = (status_reg & ~status_clr) | (status_set & `ST_W1C_MASK);
		if (wr_status && bus.wr_lanes[`ST_SINGLE_CLEAR_MODE]) begin
			status_next[`ST_SINGLE_CLEAR_MODE] = bus.wr_data[`ST_SINGLE_CLEAR_MODE];
		end
	end

	// Pending bits share the status layout; a read of the pending word clears what it showed.
	assign pending_clr = rd_pending ? pending_reg : `RESET_WORD;
	assign pending_next = (pending_reg & ~pending_clr) | (status_set & `ST_W1C_MASK);

	assign compare_irq_o = (status_reg[`ST_COMPARE_IRQ_FLAG_0] && compare_irq_enable_0)
		|| (status_reg[`ST_COMPARE_IRQ_FLAG_1] && compare_irq_enable_1);
	assign irq_o = |(pending_reg & mask_reg);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			compare_config_0_reg <= `RESET_WORD;
			compare_config_1_reg <= `RESET_WORD;
			mask_reg <= `RESET_WORD;
		end else begin
			if (wr_cfg0) begin
				compare_config_0_reg <= (compare_config_0_reg & ~(bus.wr_lanes & `CFG_WRITABLE))
					| (bus.wr_data & bus.wr_lanes & `CFG_WRITABLE);
			end
			if (wr_cfg1) begin
				compare_config_1_reg <= (compare_config_1_reg & ~(bus.wr_lanes & `CFG_WRITABLE))
					| (bus.wr_data & bus.wr_lanes & `CFG_WRITABLE);
			end
			if (wr_mask) begin
				mask_reg <= (mask_reg & ~(bus.wr_lanes & `ST_W1C_MASK))
					| (bus.wr_data & bus.wr_lanes & `ST_W1C_MASK);
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			status_reg <= `RESET_WORD;
			pending_reg <= `RESET_WORD;
			queue_half_d_reg <= 1'b0;
			queue_overflow_d_reg <= 1'b0;
			// An empty queue is the idle state, so this avoids a false empty event after reset.
			queue_empty_d_reg <= 1'b1;
			queue_full_d_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			pending_reg <= pending_next;
			queue_half_d_reg <= queue_half_i;
			queue_overflow_d_reg <= queue_overflow_i;
			queue_empty_d_reg <= queue_empty_i;
			queue_full_d_reg <= queue_full_i;
		end
	end

endmodule // adc_result_compare_status

/* adc_cmp_consts.svh */
// Purpose: Offsets, field positions, reset values and widths of the compare/status block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus.
// Notes: Definitions only; included by bare name.
`ifndef ADC_CMP_CONSTS_SVH
`define ADC_CMP_CONSTS_SVH

`define ADDR_W 8
`define DATA_W 32
`define OFS_COMPARE_CONFIG_0 8'h28
`define OFS_COMPARE_CONFIG_1 8'h2c
`define OFS_CONVERTER_STATUS 8'h30
`define OFS_IRQ_PENDING 8'h34
`define OFS_IRQ_MASK 8'h38
`define RESET_WORD 32'h0000_0000

`define CFG_REF_HI 27
`define CFG_REF_LO 16
`define CFG_THR_HI 11
`define CFG_THR_LO 8
`define CFG_CH_HI 6
`define CFG_CH_LO 3
`define CFG_COND 2
`define CFG_IE 1
`define CFG_EN 0
`define CFG_WRITABLE 32'h0fff_0f7f

`define ST_QUEUE_HALF 30
`define ST_QUEUE_OVERFLOW 29
`define ST_QUEUE_EMPTY 28
`define ST_QUEUE_FULL 27
`define ST_COMPARE_FLAG_1 26
`define ST_COMPARE_FLAG_0 25
`define ST_CONV_END 24
`define ST_QUEUE_HALF_IRQ 22
`define ST_QUEUE_OVERFLOW_IRQ 21
`define ST_QUEUE_EMPTY_IRQ 20
`define ST_QUEUE_FULL_IRQ 19
`define ST_SINGLE_DONE 18
`define ST_SINGLE_CLEAR_MODE 17
`define ST_COMPARE_IRQ_FLAG_1 2
`define ST_COMPARE_IRQ_FLAG_0 1
`define ST_W1C_MASK 32'h7f7c_0006

`define RESULT_W 12
`define THRESHOLD_W 4
`define CHANNEL_W 4
`define MATCH_CNT_W 5
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* adc_cmp_pkg.sv */
// Purpose: Types shared by the compare/status block.
// Assumes: Constants come from adc_cmp_consts.svh.
// Notes: Channel states are Gray coded along their usual path.
package adc_cmp_pkg;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b00,
		WR_RESPOND = 2'b01
	} wr_state_e;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_RESPOND = 2'b01
	} rd_state_e;

	typedef logic [31:0] word_t;

endpackage

/* adc_cmp_links_if.sv */
// Purpose: Bundles between the top and its bus slave and comparators.
// Assumes: One clock domain.
// Notes: Decode stays in the top; the slave only moves words.
`timescale 1ns/1ps
`include "adc_cmp_consts.svh"

interface reg_access_if;
	logic wr_en;
	logic [`ADDR_W-1:0] wr_addr;
	logic [`DATA_W-1:0] wr_data;
	logic [`DATA_W-1:0] wr_lanes;
	logic wr_hit;
	logic rd_en;
	logic [`ADDR_W-1:0] rd_addr;
	logic [`DATA_W-1:0] rd_data;
	logic rd_hit;
	modport slave (output wr_en, wr_addr, wr_data, wr_lanes, rd_en, rd_addr,
		input wr_hit, rd_data, rd_hit);
	modport regs (input wr_en, wr_addr, wr_data, wr_lanes, rd_en, rd_addr,
		output wr_hit, rd_data, rd_hit);
endinterface // reg_access_if

interface compare_unit_if;
	logic [`RESULT_W-1:0] compare_reference;
	logic [`THRESHOLD_W-1:0] match_count_threshold;
	logic [`CHANNEL_W-1:0] compare_channel_select;
	logic compare_condition;
	logic compare_function_enable;
	logic result_load;
	logic [`CHANNEL_W-1:0] result_channel;
	logic [`RESULT_W-1:0] result_value;
	logic hit;
	modport unit (input compare_reference, match_count_threshold, compare_channel_select,
		compare_condition, compare_function_enable, result_load, result_channel,
		result_value, output hit);
	modport cfg (output compare_reference, match_count_threshold, compare_channel_select,
		compare_condition, compare_function_enable, result_load, result_channel,
		result_value, input hit);
endinterface // compare_unit_if

/* result_comparator.sv */
// Purpose: One result comparator with its match counter.
// Assumes: result_load pulses once per result written to the data register.
// Notes: hit is a one-cycle pulse when the counted matches reach threshold plus one.
`timescale 1ns/1ps
`include "adc_cmp_consts.svh"

module result_comparator (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	compare_unit_if.unit cmp
);

	logic [`MATCH_CNT_W-1:0] match_cnt_reg;
	logic [`MATCH_CNT_W-1:0] match_cnt_next;
	logic hit_reg;
	logic channel_ok;
	logic below;
	logic cond_met;
	logic count_now;
	logic [`MATCH_CNT_W-1:0] cnt_plus;
	logic [`MATCH_CNT_W-1:0] target;
	logic reached;

	assign channel_ok = cmp.result_channel == cmp.compare_channel_select;
	assign below = cmp.result_value < cmp.compare_reference;
	assign cond_met = cmp.compare_condition ? !below : below;
	assign count_now = cmp.compare_function_enable && cmp.result_load && channel_ok
		&& cond_met;
	assign cnt_plus = match_cnt_reg + `MATCH_CNT_W'(1);
	assign target = {1'b0, cmp.match_count_threshold} + `MATCH_CNT_W'(1);
	assign reached = count_now && (cnt_plus == target);
	assign cmp.hit = hit_reg;

	always_comb begin
		match_cnt_next = match_cnt_reg;
		if (!cmp.compare_function_enable || reached) begin
			match_cnt_next = '0;
		end else if (count_now) begin
			match_cnt_next = cnt_plus;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			match_cnt_reg <= '0;
			hit_reg <= 1'b0;
		end else begin
			match_cnt_reg <= match_cnt_next;
			hit_reg <= reached;
		end
	end

endmodule // result_comparator

/* axil_reg_slave.sv */
// Purpose: AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes: One write and one read under way at a time.
// Notes: Address and data of a write are accepted in either order.
`timescale 1ns/1ps
`include "adc_cmp_consts.svh"

module axil_reg_slave (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [`ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [`DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [`ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [`DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	reg_access_if.slave bus
);

	adc_cmp_pkg::wr_state_e wr_state_reg;
	adc_cmp_pkg::rd_state_e rd_state_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [`ADDR_W-1:0] awaddr_reg;
	logic [`DATA_W-1:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_take;
	logic w_take;
	logic ar_take;

	assign s_axi_awready_o = (wr_state_reg == adc_cmp_pkg::WR_COLLECT) && !aw_held_reg;
	assign s_axi_wready_o = (wr_state_reg == adc_cmp_pkg::WR_COLLECT) && !w_held_reg;
	assign s_axi_arready_o = rd_state_reg == adc_cmp_pkg::RD_IDLE;
	assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
	assign w_take = s_axi_wvalid_i && s_axi_wready_o;
	assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
	assign s_axi_bvalid_o = wr_state_reg == adc_cmp_pkg::WR_RESPOND;
	assign s_axi_rvalid_o = rd_state_reg == adc_cmp_pkg::RD_RESPOND;

	// The write strobe fires for one cycle once both halves are held.
	assign bus.wr_en = aw_held_reg && w_held_reg;
	assign bus.wr_addr = awaddr_reg;
	assign bus.wr_data = wdata_reg;
	assign bus.wr_lanes = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}},
		{8{wstrb_reg[0]}}};
	assign bus.rd_en = ar_take;
	assign bus.rd_addr = s_axi_araddr_i;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr_i;
			end else if (bus.wr_en) begin
				aw_held_reg <= 1'b0;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata_i;
				wstrb_reg <= s_axi_wstrb_i;
			end else if (bus.wr_en) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_state_reg <= adc_cmp_pkg::WR_COLLECT;
			s_axi_bresp_o <= `RESP_OKAY;
		end else begin
			unique case (wr_state_reg)
				adc_cmp_pkg::WR_COLLECT: begin
					if (bus.wr_en) begin
						wr_state_reg <= adc_cmp_pkg::WR_RESPOND;
						s_axi_bresp_o <= bus.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
					end
				end
				adc_cmp_pkg::WR_RESPOND: begin
					if (s_axi_bready_i) begin
						wr_state_reg <= adc_cmp_pkg::WR_COLLECT;
					end
				end
				default: wr_state_reg <= adc_cmp_pkg::WR_COLLECT;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_state_reg <= adc_cmp_pkg::RD_IDLE;
			s_axi_rdata_o <= '0;
			s_axi_rresp_o <= `RESP_OKAY;
		end else begin
			unique case (rd_state_reg)
				adc_cmp_pkg::RD_IDLE: begin
					if (ar_take) begin
						rd_state_reg <= adc_cmp_pkg::RD_RESPOND;
						s_axi_rdata_o <= bus.rd_data;
						s_axi_rresp_o <= bus.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
					end
				end
				adc_cmp_pkg::RD_RESPOND: begin
					if (s_axi_rready_i) begin
						rd_state_reg <= adc_cmp_pkg::RD_IDLE;
					end
				end
				default: rd_state_reg <= adc_cmp_pkg::RD_IDLE;
			endcase
		end
	end

endmodule // axil_reg_slave

/* adc_result_compare_status_props.sv */
// Purpose: Port-level properties of the compare/status block.
// Assumes: One clock domain; bound to the top module.
// Notes: Flag registers are hidden, so bus and interrupt timing carry the checks.
`timescale 1ns/1ps
`include "adc_cmp_consts.svh"

module adc_result_compare_status_props (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [`ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic [`DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [`ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [`DATA_W-1:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic result_load_i,
	input wire logic [`CHANNEL_W-1:0] result_channel_i,
	input wire logic [`RESULT_W-1:0] result_value_i,
	input wire logic conv_start_i,
	input wire logic conv_end_i,
	input wire logic pwm_single_seq_i,
	input wire logic queue_half_i,
	input wire logic queue_overflow_i,
	input wire logic queue_empty_i,
	input wire logic queue_full_i,
	input wire logic compare_irq_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	sequence s_wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	property p_wr_resp; s_wr_take |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer mistimed");
	property p_rd_resp; s_rd_take |=> s_axi_rvalid_o; endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_unmapped;
		s_rd_take ##0 (s_axi_araddr_i < 8'h28 || s_axi_araddr_i > 8'h38)
			|=> s_axi_rresp_o == `RESP_SLVERR && s_axi_rdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_st_rsvd;
		s_rd_take ##0 (s_axi_araddr_i == `OFS_CONVERTER_STATUS)
			|=> (s_axi_rdata_o & 32'h8081_fff9) == 32'h0;
	endproperty
	a_st_rsvd: assert property (p_st_rsvd) else $error("status reserved bit set");
	property p_cfg_rsvd;
		s_rd_take ##0 (s_axi_araddr_i[7:3] == 5'h05)
			|=> (s_axi_rdata_o & ~`CFG_WRITABLE) == 32'h0;
	endproperty
	a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config reserved bit set");
	property p_cmp_irq;
		$rose(compare_irq_o) |-> $past(result_load_i, 2) || $past(result_load_i, 3)
			|| $rose(s_axi_bvalid_o);
	endproperty
	a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq without cause");
	property p_irq_fall;
		$fell(irq_o) |-> s_axi_rvalid_o || $past(s_axi_rvalid_o) || $rose(s_axi_bvalid_o);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
endmodule // adc_result_compare_status_props

bind adc_result_compare_status adc_result_compare_status_props u_props (.*);

/* adc_result_compare_status_tb_top.sv */
// Purpose: Self-checking bench for the compare/status block.
// Assumes: Single clock; the bench plays bus master and converter.
// Notes: Channel picks and values near the reference are random from a fixed seed.
`timescale 1ns/1ps
`include "adc_cmp_consts.svh"

module adc_result_compare_status_tb_top;
	logic clk_sys_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_arready_o, s_axi_rvalid_o, compare_irq_o, irq_o, pwm_single_seq_i;
	logic result_load_i, conv_start_i, conv_end_i;
	logic queue_half_i, queue_overflow_i, queue_empty_i, queue_full_i;
	logic [`ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_word;
	logic [3:0] s_axi_wstrb_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
	logic [`CHANNEL_W-1:0] result_channel_i;
	logic [`RESULT_W-1:0] result_value_i;
	logic [6:0] evs;
	int failures, n_tests, cyc;
	assign {result_load_i, conv_start_i, conv_end_i, queue_half_i} = evs[6:3];
	assign {queue_overflow_i, queue_empty_i, queue_full_i} = evs[2:0];

	adc_result_compare_status u_dut (.*);

	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	task automatic complete_run;
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Handshakes are judged on values held over the second half-cycle, so the
	// decision never races the edge that updates the slave.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(negedge clk_sys_i);
			ha = s_axi_awvalid_i & s_axi_awready_o;
			hw = s_axi_wvalid_i & s_axi_wready_o;
			hb = s_axi_bvalid_o;
			resp = s_axi_bresp_o;
			@(posedge clk_sys_i);
			if (ha) s_axi_awvalid_i <= 1'b0;
			if (hw) s_axi_wvalid_i <= 1'b0;
		end
		s_axi_bready_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		logic hr, hv;
		@(posedge clk_sys_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		hv = 1'b0;
		while (!hv) begin
			@(negedge clk_sys_i);
			hr = s_axi_arvalid_i & s_axi_arready_o;
			hv = s_axi_rvalid_o;
			rd_word = s_axi_rdata_o;
			resp = s_axi_rresp_o;
			@(posedge clk_sys_i);
			if (hr) s_axi_arvalid_i <= 1'b0;
		end
		s_axi_rready_i <= 1'b0;
	endtask

	task automatic stim(input logic [6:0] m, input logic [3:0] c, input logic [11:0] v);
		@(posedge clk_sys_i);
		evs <= m;
		result_channel_i <= c;
		result_value_i <= v;
		@(posedge clk_sys_i);
		evs <= 7'h00;
		repeat (3) @(posedge clk_sys_i);
	endtask

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		logic [31:0] d, e;
		logic [11:0] rf, v;
		logic [3:0] thr, ch, c;
		logic [4:0] cnt;
		logic k, cond, ie, en, flg;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = 4'h0;
		{s_axi_rready_i, pwm_single_seq_i, s_axi_awaddr_i, s_axi_araddr_i} = 18'h0;
		{s_axi_wdata_i, result_channel_i, result_value_i, evs} = 55'h0;
		s_axi_wstrb_i = 4'hf;
		rst_i = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		void'($urandom(32'hd0c4));
		for (int a = 8'h28; a <= 8'h38; a += 4) begin
			rd(8'(a));
			chk("reset_word", `RESET_WORD, rd_word);
		end
		rd(8'h00);
		chk("unmapped_rresp", 32'(`RESP_SLVERR), 32'(resp));
		wr(8'h3c, 32'hffff_ffff);
		chk("unmapped_bresp", 32'(`RESP_SLVERR), 32'(resp));
		d = $urandom;
		wr(8'h28, d);
		chk("mapped_bresp", 32'(`RESP_OKAY), 32'(resp));
		rd(8'h28);
		chk("config_readback", d & `CFG_WRITABLE, rd_word);
		chk("mapped_rresp", 32'(`RESP_OKAY), 32'(resp));
		rd(8'h40);
		chk("unmapped_rresp_late", 32'(`RESP_SLVERR), 32'(resp));
		wr(8'h28, 32'h0);
		for (int r = 0; r < 12; r++) begin
			k = r[0];
			cond = r[1];
			ie = r[2];
			en = (r != 6);
			thr = 4'($urandom_range(2, 0));
			ch = 4'($urandom_range(7, 0));
			rf = $urandom;
			rf = r[3] ? {12{r[2]}} : rf;
			wr({5'h05, k, 2'h0}, {4'h0, rf, 4'h0, thr, 1'b0, ch, cond, ie, en});
			cnt = 5'h0;
			flg = 1'b0;
			repeat (6) begin
				v = rf - 12'h1 + 12'($urandom_range(2, 0));
				c = ($urandom_range(3, 0) == 0) ? ch ^ 4'h1 : ch;
				stim(7'h40, c, v);
				if (en && c == ch && (cond ? v >= rf : v < rf)) cnt++;
				if (cnt == {1'b0, thr} + 5'h1) begin
					flg = 1'b1;
					cnt = 5'h0;
				end
				rd(8'h30);
				e = (32'(flg) << (25 + k)) | (32'(flg) << (1 + k));
				chk("compare_status", e, rd_word);
				chk("compare_irq", 32'(flg & ie), 32'(compare_irq_o));
			end
			wr(8'h30, 32'h0);
			rd(8'h30);
			chk("write_zero", e, rd_word);
			wr(8'h30, e);
			rd(8'h30);
			chk("compare_clear", 32'h0, rd_word);
			wr({5'h05, k, 2'h0}, 32'h0);
		end
		wr(8'h38, 32'h0100_0000);
		wr(8'h30, 32'h0002_0000);
		pwm_single_seq_i <= 1'b1;
		stim(7'h10, 4'h0, 12'h0);
		rd(8'h30);
		chk("conv_end", 32'h0106_0000, rd_word);
		chk("irq_level", 32'h1, 32'(irq_o));
		rd(8'h34);
		chk("pending", 32'h0100_0000, rd_word & 32'h0100_0000);
		chk("irq_cleared", 32'h0, 32'(irq_o));
		stim(7'h20, 4'h0, 12'h0);
		rd(8'h30);
		chk("hw_clear", 32'h0102_0000, rd_word);
		wr(8'h30, 32'h0100_0000);
		stim(7'h10, 4'h0, 12'h0);
		stim(7'h20, 4'h0, 12'h0);
		rd(8'h30);
		chk("sw_mode_hold", 32'h0104_0000, rd_word);
		wr(8'h30, 32'h0104_0000);
		for (int i = 0; i < 4; i++) begin
			stim(7'(1 << i), 4'h0, 12'h0);
			d = (32'h1 << (27 + i)) | (32'h1 << (19 + i));
			rd(8'h30);
			chk("queue_flags", d, rd_word);
			wr(8'h30, d);
			rd(8'h30);
			chk("queue_clear", 32'h0, rd_word);
		end
		chk("irq_level_again", 32'h1, 32'(irq_o));
		rd(8'h34);
		chk("pending_word", 32'h797c_0000, rd_word);
		chk("irq_quiet", 32'h0, 32'(irq_o));
		complete_run();
	end
endmodule // adc_result_compare_status_tb_top
